// ### logic/user_io_defs.svh
// Constants for the user I/O connector logic
`ifndef USER_IO_DEFS_SVH
`define USER_IO_DEFS_SVH

// Footswitch mode encodings
`define FSW_MODE_TOGGLE 2'h0
`define FSW_MODE_FOLLOW 2'h1
`define FSW_MODE_INVERT 2'h2

// Reset values and direction encodings
`define TRIG_OUT_RESET 1'h0
`define DIR_INFUSE 1'h0
`define DIR_REFILL 1'h1

// Least input pulse width the far side holds, in ms, and the clock rate
`define MIN_PULSE_MS 100
`define CLK_HZ 50000000

`endif

// ### logic/user_io_pkg.sv
// Types for the user I/O connector logic
package user_io_pkg;

    // Footswitch mode selector
    typedef enum logic [1:0]
    {
        FSW_TOGGLE = 2'h0,
        FSW_FOLLOW = 2'h1,
        FSW_INVERT = 2'h2,
        FSW_SPARE = 2'h3
    } fsw_mode_type;

    // Synchronised edges of the three inputs
    typedef struct packed
    {
        logic dir_rise;
        logic dir_fall;
        logic evt_fall;
        logic fsw_rise;
        logic fsw_fall;
    } in_edges_type;

    // Output pin group
    typedef struct packed
    {
        logic trig1;
        logic trig2;
        logic sync;
        logic dir;
        logic valve;
        logic run_led_n;
    } out_pins_type;

endpackage : user_io_pkg

// ### logic/input_edge_sync.sv
// Two-stage synchroniser with edge detection for one input
module input_edge_sync
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Raw pin and detected edges
    input wire logic pin,
    output logic rise,
    output logic fall
);
    typedef struct packed
    {
        logic meta;
        logic stable;
        logic prev;
    } sync_state_type;

    sync_state_type state_reg;
    sync_state_type state_next;

    // Inputs are pulled high, so idle level is one
    always_comb
    begin
        state_next = state_reg;
        state_next.meta = pin;
        state_next.stable = state_reg.meta;
        state_next.prev = state_reg.stable;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            state_reg <= 3'h7;
        else
            state_reg <= state_next;
    end

    // Compare successive sampled values, never the first stage
    assign rise = state_reg.stable & ~state_reg.prev;
    assign fall = ~state_reg.stable & state_reg.prev;
endmodule : input_edge_sync

// ### logic/pump_user_io_controller.sv
// User I/O connector logic of the pump controller
// Summary of operation
// - Direction input rising sets infuse, falling sets refill.
// - Event trigger input falling edge fires one program event pulse.
// - Toggle mode: footswitch falling edge toggles run and stop.
// - Follow mode: footswitch rising starts, falling stops pumping.
// - Inverted mode: falling starts, rising stops; setting selects mode.
// - Two trigger outputs reset low, set only by method or command.
// - Sync output rises at infuse start, falls at refill start.
// - Direction output high in refill, low in infuse.
// - Valve output high actuates valve, low leaves it off.
// - Automatic valve setting makes valve follow direction changes.
// - Run indicator low while running, high while stopped.
`include "user_io_defs.svh"

module pump_user_io_controller
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Connector inputs
    input wire logic dir_in,
    input wire logic event_in,
    input wire logic footswitch_in,
    // Configuration
    input wire user_io_pkg::fsw_mode_type fsw_mode,
    input wire logic valve_auto,
    // Method or serial commands
    input wire logic trig1_set,
    input wire logic trig1_clr,
    input wire logic trig2_set,
    input wire logic trig2_clr,
    input wire logic valve_cmd_on,
    input wire logic valve_cmd_off,
    input wire logic run_cmd,
    input wire logic stop_cmd,
    input wire logic infuse_cmd,
    input wire logic refill_cmd,
    // Connector outputs
    output user_io_pkg::out_pins_type pins,
    // Internal state towards the controller
    output logic running,
    output logic refill_dir,
    output logic event_pulse
);
    typedef struct packed
    {
        user_io_pkg::out_pins_type pins;
        logic running;
        logic refill_dir;
        logic event_pulse;
    } ctrl_state_type;

    ctrl_state_type state_reg;
    ctrl_state_type state_next;
    user_io_pkg::in_edges_type edges;

    // One synchroniser per connector input
    input_edge_sync u_dir_sync
    (
        .clk(clk),
        .reset_n(reset_n),
        .pin(dir_in),
        .rise(edges.dir_rise),
        .fall(edges.dir_fall)
    );

    input_edge_sync u_evt_sync
    (
        .clk(clk),
        .reset_n(reset_n),
        .pin(event_in),
        .rise(),
        .fall(edges.evt_fall)
    );

    input_edge_sync u_fsw_sync
    (
        .clk(clk),
        .reset_n(reset_n),
        .pin(footswitch_in),
        .rise(edges.fsw_rise),
        .fall(edges.fsw_fall)
    );

    // Footswitch decode; spare mode code acts as no footswitch at all
    function automatic logic [1:0] fsw_action(
        input user_io_pkg::fsw_mode_type mode,
        input logic rise,
        input logic fall,
        input logic run_now
    );
        logic start;
        logic stop;
        start = 1'h0;
        stop = 1'h0;
        case (mode)
            user_io_pkg::FSW_TOGGLE:
            begin
                start = fall & ~run_now;
                stop = fall & run_now;
            end
            user_io_pkg::FSW_FOLLOW:
            begin
                start = rise;
                stop = fall;
            end
            user_io_pkg::FSW_INVERT:
            begin
                start = fall;
                stop = rise;
            end
            default:
            begin
                start = 1'h0;
                stop = 1'h0;
            end
        endcase
        return {start, stop};
    endfunction : fsw_action

    // Next state of direction, run, valve and trigger outputs
    always_comb
    begin
        logic [1:0] act;
        logic dir_new;
        logic run_new;
        act = fsw_action(fsw_mode, edges.fsw_rise, edges.fsw_fall,
            state_reg.running);
        state_next = state_reg;
        dir_new = state_reg.refill_dir;
        run_new = state_reg.running;

        // Pin edges take priority over commands in the same cycle
        if (infuse_cmd)
            dir_new = `DIR_INFUSE;
        else if (refill_cmd)
            dir_new = `DIR_REFILL;
        if (edges.dir_rise)
            dir_new = `DIR_INFUSE;
        else if (edges.dir_fall)
            dir_new = `DIR_REFILL;

        if (run_cmd)
            run_new = 1'h1;
        else if (stop_cmd)
            run_new = 1'h0;
        if (act[1])
            run_new = 1'h1;
        else if (act[0])
            run_new = 1'h0;

        state_next.refill_dir = dir_new;
        state_next.running = run_new;
        state_next.event_pulse = edges.evt_fall;

        // Outputs follow the state being registered now
        state_next.pins.dir = dir_new;
        state_next.pins.sync = ~dir_new;
        state_next.pins.run_led_n = ~run_new;

        // Valve: commands, or direction tracking when automatic
        if (valve_auto)
        begin
            if (dir_new != state_reg.refill_dir)
                state_next.pins.valve = ~state_reg.pins.valve;
        end
        else if (valve_cmd_on)
            state_next.pins.valve = 1'h1;
        else if (valve_cmd_off)
            state_next.pins.valve = 1'h0;

        // Trigger outputs change only by command; set wins over clear
        if (trig1_set)
            state_next.pins.trig1 = 1'h1;
        else if (trig1_clr)
            state_next.pins.trig1 = 1'h0;
        if (trig2_set)
            state_next.pins.trig2 = 1'h1;
        else if (trig2_clr)
            state_next.pins.trig2 = 1'h0;
    end

    // Reset: infuse, stopped, valve off, triggers low, sync high
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            state_reg <= {`TRIG_OUT_RESET, `TRIG_OUT_RESET, 1'h1,
                `DIR_INFUSE, 1'h0, 1'h1, 1'h0, `DIR_INFUSE, 1'h0};
        else
            state_reg <= state_next;
    end

    assign pins = state_reg.pins;
    assign running = state_reg.running;
    assign refill_dir = state_reg.refill_dir;
    assign event_pulse = state_reg.event_pulse;
endmodule : pump_user_io_controller

// ### verification/user_io_props.sv
// Checker of the user I/O connector timing
module user_io_props
(
    // Clock, reset and pins
    input wire logic clk,
    input wire logic reset_n,
    input wire logic dir_in,
    input wire logic event_in,
    input wire logic footswitch_in,
    // Settings and commands
    input wire user_io_pkg::fsw_mode_type fsw_mode,
    input wire logic valve_auto,
    input wire logic trig1_set,
    // Results
    input wire user_io_pkg::out_pins_type pins,
    input wire logic running,
    input wire logic refill_dir,
    input wire logic event_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Pin edges pass a synchroniser, so allow two to four edges
    dir_fall_a: assert property (
        $fell(dir_in) |-> ##[2:4] refill_dir)
        else $error("refill late");
    event_fire_a: assert property (
        $fell(event_in) |-> ##[2:4] event_pulse)
        else $error("event late");
    toggle_stop_a: assert property (
        fsw_mode == 2'h0 && $fell(footswitch_in) && running
        |-> ##[2:4] !running)
        else $error("toggle stop late");
    follow_start_a: assert property (
        fsw_mode == 2'h1 && $rose(footswitch_in)
        |-> ##[2:4] running)
        else $error("follow start late");
    invert_start_a: assert property (
        fsw_mode == 2'h2 && $fell(footswitch_in)
        |-> ##[2:4] running)
        else $error("invert start late");
    trig_set_a: assert property (
        trig1_set |=> pins.trig1)
        else $error("trigger not set");
    dir_sync_a: assert property (
        pins.dir == refill_dir && pins.sync != refill_dir)
        else $error("dir or sync wrong");
    valve_track_a: assert property (
        valve_auto && $changed(refill_dir) |-> $changed(pins.valve))
        else $error("valve kept");
    led_run_a: assert property (
        pins.run_led_n != running)
        else $error("led wrong");
    // Main scenarios
    cover property (running ##1 !running);
    cover property (event_pulse);
    cover property (valve_auto && $changed(pins.valve));
endmodule : user_io_props

// ### verification/user_io_far_side.sv
// Far-side TTL equipment driving the connector inputs
module user_io_far_side
#(
    parameter int HOLD_CYC = 8
)
(
    input wire logic clk,
    output logic dir_in,
    output logic event_in,
    output logic footswitch_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-ups keep every input high while idle
    initial {dir_in, event_in, footswitch_in} = 3'h7;
    // Hold time shortened from 0.1 s so the run stays brief
    task drive(input int i, input logic v);
        @(negedge clk);
        case (i)
            0: dir_in = v;
            1: event_in = v;
            default: footswitch_in = v;
        endcase
        repeat (HOLD_CYC) @(negedge clk);
    endtask : drive
endmodule : user_io_far_side

// ### verification/tb_pump_user_io_controller.sv
// Self-checking bench of the user I/O connector logic
module tb_pump_user_io_controller;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset_n = 0, valve_auto = 0;
    logic [9:0] cmd = '0;
    user_io_pkg::fsw_mode_type fsw_mode = user_io_pkg::FSW_TOGGLE;
    user_io_pkg::out_pins_type pins;
    logic running, refill_dir, event_pulse, dir_in, event_in, footswitch_in;
    logic t1 = 0, t2 = 0, vl = 0, run = 0, rf = 0;
    logic [8:0] q[$];
    logic [7:0] last;
    int n_fail = 0, n_compared = 0;

    user_io_far_side #(.HOLD_CYC(8)) far (.clk, .dir_in, .event_in,
        .footswitch_in);
    pump_user_io_controller DUT (.clk, .reset_n, .dir_in, .event_in,
        .footswitch_in, .fsw_mode, .valve_auto, .trig1_set(cmd[0]),
        .trig1_clr(cmd[1]), .trig2_set(cmd[2]), .trig2_clr(cmd[3]),
        .valve_cmd_on(cmd[4]), .valve_cmd_off(cmd[5]), .run_cmd(cmd[6]),
        .stop_cmd(cmd[7]), .infuse_cmd(cmd[8]), .refill_cmd(cmd[9]),
        .pins, .running, .refill_dir, .event_pulse);

    initial forever #10 clk = ~clk;

    // Expected output word as the rules describe it
    function logic [8:0] expv(input logic ev);
        return {t1, t2, !rf, rf, vl, !run, run, rf, ev};
    endfunction : expv

    task check(input string what, input logic [8:0] e, input logic [8:0] a);
        n_compared++;
        if (e !== a)
        begin
            $display("unexpected %s: expected %h seen %h", what, e, a);
            n_fail++;
        end
    endtask : check

    task summarize;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    // Direction change drags the valve along in auto mode
    task new_dir(input logic r);
        if (valve_auto && r != rf)
            vl = !vl;
        rf = r;
    endtask : new_dir

    // One command pulse; note the result only if something moves
    task step(input int k);
        logic [8:0] old;
        old = expv(0);
        case (k)
            0: t1 = 1;
            1: t1 = 0;
            2: t2 = 1;
            3: t2 = 0;
            4: if (!valve_auto) vl = 1;
            5: if (!valve_auto) vl = 0;
            6: run = 1;
            7: run = 0;
            8: new_dir(0);
            default: new_dir(1);
        endcase
        if (expv(0) != old) q.push_back(expv(0));
        @(negedge clk) cmd = 10'h001 << k;
        @(negedge clk) cmd = '0;
        repeat (3) @(negedge clk);
    endtask : step

    // One pin edge through the far side
    task pin(input int i, input logic v);
        logic [8:0] old;
        old = expv(0);
        if (i == 0)
            new_dir(!v);
        if (i == 2 && v)
            run = fsw_mode == 2'h1 ? 1 : fsw_mode == 2'h2 ? 0 : run;
        if (i == 2 && !v)
            run = fsw_mode == 2'h0 ? !run :
                fsw_mode == 2'h1 ? 0 : fsw_mode == 2'h2 ? 1 : run;
        if (i == 1 && !v) q.push_back(expv(1));
        else if (expv(0) != old) q.push_back(expv(0));
        far.drive(i, v);
    endtask : pin

    // Any output movement takes the oldest note; none left means spurious
    always @(posedge clk)
    begin
        #1;
        if (reset_n && ({pins, running, refill_dir} !== last || event_pulse))
            check("outputs", q.size() > 0 ? q.pop_front() : 9'h1ff,
                {pins, running, refill_dir, event_pulse});
        last = {pins, running, refill_dir};
    end

    initial
    begin
        void'($urandom(49875));
        repeat (10) @(negedge clk);
        reset_n = 1;
        check("reset values", 9'h048, {pins, running, refill_dir, event_pulse});
        $display("reset test done");
        repeat (24)
        begin
            valve_auto = 1'($urandom_range(1));
            step($urandom_range(9));
        end
        $display("command test done");
        valve_auto = 1;
        pin(0, 0);
        pin(0, 1);
        pin(1, 0);
        pin(1, 1);
        $display("direction and event test done");
        for (int m = 0; m < 4; m++)
        begin
            fsw_mode = user_io_pkg::fsw_mode_type'(m);
            repeat (2)
            begin
                pin(2, 0);
                pin(2, 1);
            end
        end
        $display("footswitch test done");
        repeat (5) @(negedge clk);
        check("notes left", 9'h000, 9'(q.size()));
        summarize();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge clk);
        n_fail++;
        summarize();
    end
endmodule : tb_pump_user_io_controller

bind pump_user_io_controller user_io_props checker_i (.*);
